// ===== verilog/pioc_pkg.sv
// constants for the parallel port line control block
// Functional notes
// R1 - owner enable write 1 gives port the pin
// R2 - owner disable write 1 gives peripheral the pin
// R3 - owner status reads 1 where port owns
// R4 - driver enable write 1 turns driver on
// R5 - driver disable write 1 turns driver off
// R6 - driver status reads 1 where driver on
// R7 - filter enable write 1 turns filter on
// R8 - filter disable write 1 turns filter off
// R9 - filter status reads 1 where filter on
// R10 - level set write 1 sets output level
// R11 - level clear write 1 clears output level
// R12 - level status reads scheduled output level
// R13 - all registers 32 bits, bit n line n
// R14 - level status writable only where direct-write on
// R15 - unimplemented line bits ignore writes, read zero
// R16 - unmultiplexed lines always port owned
// R17 - pin driven when port owns and driver on
package pioc_pkg;
    localparam int          PIOC_DW              = 32;
    localparam logic [7:0]  PIOC_OWNER_EN_OFF    = 8'h00;
    localparam logic [7:0]  PIOC_OWNER_DIS_OFF   = 8'h04;
    localparam logic [7:0]  PIOC_OWNER_STAT_OFF  = 8'h08;
    localparam logic [7:0]  PIOC_DRV_EN_OFF      = 8'h10;
    localparam logic [7:0]  PIOC_DRV_DIS_OFF     = 8'h14;
    localparam logic [7:0]  PIOC_DRV_STAT_OFF    = 8'h18;
    localparam logic [7:0]  PIOC_FLT_EN_OFF      = 8'h20;
    localparam logic [7:0]  PIOC_FLT_DIS_OFF     = 8'h24;
    localparam logic [7:0]  PIOC_FLT_STAT_OFF    = 8'h28;
    localparam logic [7:0]  PIOC_LVL_SET_OFF     = 8'h30;
    localparam logic [7:0]  PIOC_LVL_CLR_OFF     = 8'h34;
    localparam logic [7:0]  PIOC_LVL_STAT_OFF    = 8'h38;
    localparam logic [7:0]  PIOC_DW_EN_OFF       = 8'ha0;
    localparam logic [7:0]  PIOC_DW_DIS_OFF      = 8'ha4;
    localparam logic [7:0]  PIOC_DW_STAT_OFF     = 8'ha8;
    localparam logic [31:0] PIOC_OWNER_RST       = 32'hffff_ffff;
    localparam logic [31:0] PIOC_DRV_RST         = 32'h0000_0000;
    localparam logic [31:0] PIOC_FLT_RST         = 32'h0000_0000;
    localparam logic [31:0] PIOC_LVL_RST         = 32'h0000_0000;
    localparam logic [31:0] PIOC_DW_RST          = 32'h0000_0000;
endpackage

// ===== verilog/pioc_line_ctrl.sv
// apb slave holding per-line ownership, driver, filter and level state
`timescale 1ns/1ns
`default_nettype none
module pioc_line_ctrl #(
    parameter logic [31:0] LINES_IMPL = 32'hffff_ffff,
    parameter logic [31:0] LINES_MUX  = 32'hffff_ffff
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic      [31:0] pin_out,
    output logic      [31:0] pin_oe,
    output logic      [31:0] periph_owned,
    output logic      [31:0] filter_on
);
    logic [31:0] owner_reg;
    logic [31:0] owner_next;
    logic [31:0] drv_reg;
    logic [31:0] drv_next;
    logic [31:0] flt_reg;
    logic [31:0] flt_next;
    logic [31:0] lvl_reg;
    logic [31:0] lvl_next;
    logic [31:0] dwr_reg;
    logic [31:0] dwr_next;
    logic [31:0] prdata_reg;
    logic [31:0] rd_mux;
    logic [31:0] wd;
    logic [7:0]  off;
    logic        wr;
    logic        rd;
    logic        hit;

    assign off = paddr[7:0];
    assign wr  = psel & penable & pwrite;
    assign rd  = psel & ~penable & ~pwrite;
    // unimplemented lines masked so they never change
    assign wd  = pwdata & LINES_IMPL; // R15

    assign hit = (paddr[31:8] == 24'h00_0000) &&
                 (off == pioc_pkg::PIOC_OWNER_EN_OFF ||
                  off == pioc_pkg::PIOC_OWNER_DIS_OFF ||
                  off == pioc_pkg::PIOC_OWNER_STAT_OFF ||
                  off == pioc_pkg::PIOC_DRV_EN_OFF ||
                  off == pioc_pkg::PIOC_DRV_DIS_OFF ||
                  off == pioc_pkg::PIOC_DRV_STAT_OFF ||
                  off == pioc_pkg::PIOC_FLT_EN_OFF ||
                  off == pioc_pkg::PIOC_FLT_DIS_OFF ||
                  off == pioc_pkg::PIOC_FLT_STAT_OFF ||
                  off == pioc_pkg::PIOC_LVL_SET_OFF ||
                  off == pioc_pkg::PIOC_LVL_CLR_OFF ||
                  off == pioc_pkg::PIOC_LVL_STAT_OFF ||
                  off == pioc_pkg::PIOC_DW_EN_OFF ||
                  off == pioc_pkg::PIOC_DW_DIS_OFF ||
                  off == pioc_pkg::PIOC_DW_STAT_OFF);

    // set/clear pairs: ones act, zeros leave the bit alone
    // unmultiplexed lines forced to port ownership
    assign owner_next = ~LINES_MUX | (!wr ? owner_reg :
        off == pioc_pkg::PIOC_OWNER_EN_OFF ? (owner_reg | wd) : // R1
        off == pioc_pkg::PIOC_OWNER_DIS_OFF ? (owner_reg & ~wd) : // R2 R16
        owner_reg);
    assign drv_next = !wr ? drv_reg :
        off == pioc_pkg::PIOC_DRV_EN_OFF ? (drv_reg | wd) : // R4
        off == pioc_pkg::PIOC_DRV_DIS_OFF ? (drv_reg & ~wd) : // R5
        drv_reg;
    assign flt_next = !wr ? flt_reg :
        off == pioc_pkg::PIOC_FLT_EN_OFF ? (flt_reg | wd) : // R7
        off == pioc_pkg::PIOC_FLT_DIS_OFF ? (flt_reg & ~wd) : // R8
        flt_reg;
    assign dwr_next = !wr ? dwr_reg :
        off == pioc_pkg::PIOC_DW_EN_OFF ? (dwr_reg | wd) :
        off == pioc_pkg::PIOC_DW_DIS_OFF ? (dwr_reg & ~wd) :
        dwr_reg;
    assign lvl_next = !wr ? lvl_reg :
        off == pioc_pkg::PIOC_LVL_SET_OFF ? (lvl_reg | wd) : // R10
        off == pioc_pkg::PIOC_LVL_CLR_OFF ? (lvl_reg & ~wd) : // R11
        off == pioc_pkg::PIOC_LVL_STAT_OFF ?
            ((lvl_reg & ~dwr_reg) | (wd & dwr_reg)) : // R14
        lvl_reg;

    assign rd_mux = LINES_IMPL & ( // R15 R13
        off == pioc_pkg::PIOC_OWNER_STAT_OFF ? owner_reg : // R3
        off == pioc_pkg::PIOC_DRV_STAT_OFF ? drv_reg : // R6
        off == pioc_pkg::PIOC_FLT_STAT_OFF ? flt_reg : // R9
        off == pioc_pkg::PIOC_LVL_STAT_OFF ? lvl_reg : // R12
        off == pioc_pkg::PIOC_DW_STAT_OFF ? dwr_reg :
        32'h0000_0000);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            owner_reg  <= pioc_pkg::PIOC_OWNER_RST;
            drv_reg    <= pioc_pkg::PIOC_DRV_RST;
            flt_reg    <= pioc_pkg::PIOC_FLT_RST;
            lvl_reg    <= pioc_pkg::PIOC_LVL_RST;
            dwr_reg    <= pioc_pkg::PIOC_DW_RST;
            prdata_reg <= 32'h0000_0000;
        end else begin
            owner_reg <= owner_next;
            drv_reg   <= drv_next;
            flt_reg   <= flt_next;
            lvl_reg   <= lvl_next;
            dwr_reg   <= dwr_next;
            // read data captured in setup so it comes from a flop
            if (rd) begin
                prdata_reg <= hit ? rd_mux : 32'h0000_0000;
            end
        end
    end

    assign prdata       = prdata_reg;
    assign pready       = 1'b1;
    assign pslverr      = psel & penable & ~hit;
    // pad driver only while port owns the line
    assign pin_oe       = owner_reg & drv_reg & LINES_IMPL; // R17
    assign pin_out      = lvl_reg & pin_oe; // R17
    assign periph_owned = ~owner_reg & LINES_IMPL;
    assign filter_on    = flt_reg & LINES_IMPL;

    a_owner_set: assert property (@(posedge pclk) disable iff (!presetn)
        wr && off == pioc_pkg::PIOC_OWNER_EN_OFF
        |=> (owner_reg & $past(wd)) == $past(wd)) // R1
        else $error("owner enable did not take");
    a_owner_clr: assert property (@(posedge pclk) disable iff (!presetn)
        wr && off == pioc_pkg::PIOC_OWNER_DIS_OFF
        |=> (owner_reg & $past(wd) & LINES_MUX) == 32'h0000_0000) // R2
        else $error("owner disable did not take");
    a_drv_set: assert property (@(posedge pclk) disable iff (!presetn)
        wr && off == pioc_pkg::PIOC_DRV_EN_OFF
        |=> (drv_reg & $past(wd)) == $past(wd)) // R4
        else $error("driver enable did not take");
    a_drv_clr: assert property (@(posedge pclk) disable iff (!presetn)
        wr && off == pioc_pkg::PIOC_DRV_DIS_OFF
        |=> (drv_reg & $past(wd)) == 32'h0000_0000) // R5
        else $error("driver disable did not take");
    a_flt_set: assert property (@(posedge pclk) disable iff (!presetn)
        wr && off == pioc_pkg::PIOC_FLT_EN_OFF
        |=> (flt_reg & $past(wd)) == $past(wd)) // R7
        else $error("filter enable did not take");
    a_flt_clr: assert property (@(posedge pclk) disable iff (!presetn)
        wr && off == pioc_pkg::PIOC_FLT_DIS_OFF
        |=> (flt_reg & $past(wd)) == 32'h0000_0000) // R8
        else $error("filter disable did not take");
    a_lvl_set: assert property (@(posedge pclk) disable iff (!presetn)
        wr && off == pioc_pkg::PIOC_LVL_SET_OFF
        |=> (lvl_reg & $past(wd)) == $past(wd)) // R10
        else $error("level set did not take");
    a_lvl_clr: assert property (@(posedge pclk) disable iff (!presetn)
        wr && off == pioc_pkg::PIOC_LVL_CLR_OFF
        |=> (lvl_reg & $past(wd)) == 32'h0000_0000) // R11
        else $error("level clear did not take");
    a_lvl_guard: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 (($past(wr) && $past(off) == pioc_pkg::PIOC_LVL_STAT_OFF)
        -> (((lvl_reg ^ $past(lvl_reg)) & ~$past(dwr_reg))
        == 32'h0000_0000))) // R14
        else $error("protected level bit changed");
    a_stat_read: assert property (@(posedge pclk) disable iff (!presetn)
        rd && hit && off == pioc_pkg::PIOC_OWNER_STAT_OFF
        |=> prdata == (LINES_IMPL & $past(owner_reg))) // R3
        else $error("owner status read wrong");
    a_unmux_own: assert property (@(posedge pclk) disable iff (!presetn)
        (owner_reg & ~LINES_MUX) == ~LINES_MUX) // R16
        else $error("unmultiplexed line lost ownership");
    a_pin_drive: assert property (@(posedge pclk) disable iff (!presetn)
        pin_oe == (owner_reg & drv_reg & LINES_IMPL)
        && (pin_out & ~lvl_reg) == 32'h0000_0000) // R17
        else $error("pin drive mismatch");

    // a read is two steps: capture in setup, present in access
    sequence s_rd_setup(logic [7:0] o);
        rd && hit && off == o;
    endsequence
    sequence s_rd_access;
        psel && penable && !pwrite;
    endsequence
    sequence s_rd_pair(logic [7:0] o);
        s_rd_setup(o) ##1 s_rd_access;
    endsequence
    sequence s_wr_at(logic [7:0] o);
        wr && off == o;
    endsequence

    a_drv_read: assert property (@(posedge pclk) disable iff (!presetn)
        s_rd_pair(pioc_pkg::PIOC_DRV_STAT_OFF)
        |-> prdata == (LINES_IMPL & $past(drv_reg))) // R6
        else $error("driver status read wrong");
    a_flt_read: assert property (@(posedge pclk) disable iff (!presetn)
        s_rd_pair(pioc_pkg::PIOC_FLT_STAT_OFF)
        |-> prdata == (LINES_IMPL & $past(flt_reg))) // R9
        else $error("filter status read wrong");
    a_lvl_read: assert property (@(posedge pclk) disable iff (!presetn)
        s_rd_pair(pioc_pkg::PIOC_LVL_STAT_OFF)
        |-> prdata == (LINES_IMPL & $past(lvl_reg))) // R12
        else $error("level status read wrong");
    a_dw_read: assert property (@(posedge pclk) disable iff (!presetn)
        s_rd_pair(pioc_pkg::PIOC_DW_STAT_OFF)
        |-> prdata == (LINES_IMPL & $past(dwr_reg))) // R14
        else $error("direct-write status read wrong");
    a_own_read: assert property (@(posedge pclk) disable iff (!presetn)
        s_rd_pair(pioc_pkg::PIOC_OWNER_STAT_OFF)
        |-> prdata == (LINES_IMPL & $past(owner_reg))) // R3
        else $error("owner status access read wrong");
    a_wo_read: assert property (@(posedge pclk) disable iff (!presetn)
        s_rd_pair(pioc_pkg::PIOC_DRV_EN_OFF)
        |-> prdata == 32'h0000_0000) // R13
        else $error("write-only register read nonzero");
    a_rd_impl: assert property (@(posedge pclk) disable iff (!presetn)
        (prdata & ~LINES_IMPL) == 32'h0000_0000) // R15
        else $error("unimplemented line read nonzero");
    a_out_impl: assert property (@(posedge pclk) disable iff (!presetn)
        ((pin_oe | pin_out | periph_owned | filter_on) & ~LINES_IMPL)
        == 32'h0000_0000) // R15
        else $error("unimplemented line output active");
    a_reg_impl: assert property (@(posedge pclk) disable iff (!presetn)
        ((drv_reg | flt_reg | lvl_reg | dwr_reg) & ~LINES_IMPL)
        == 32'h0000_0000) // R15
        else $error("unimplemented line state set");

    // zero bits of a set/clear write leave the line alone
    a_owner_zero: assert property (@(posedge pclk) disable iff (!presetn)
        s_wr_at(pioc_pkg::PIOC_OWNER_EN_OFF)
        |=> (owner_reg & ~$past(wd)) == ($past(owner_reg) & ~$past(wd)))
        else $error("owner enable touched zero bits"); // R1
    a_owner_zclr: assert property (@(posedge pclk) disable iff (!presetn)
        s_wr_at(pioc_pkg::PIOC_OWNER_DIS_OFF)
        |=> (owner_reg & ~$past(wd)) == ($past(owner_reg) & ~$past(wd)))
        else $error("owner disable touched zero bits"); // R2
    a_drv_zero: assert property (@(posedge pclk) disable iff (!presetn)
        s_wr_at(pioc_pkg::PIOC_DRV_EN_OFF)
        |=> (drv_reg & ~$past(wd)) == ($past(drv_reg) & ~$past(wd)))
        else $error("driver enable touched zero bits"); // R4
    a_drv_zclr: assert property (@(posedge pclk) disable iff (!presetn)
        s_wr_at(pioc_pkg::PIOC_DRV_DIS_OFF)
        |=> (drv_reg & ~$past(wd)) == ($past(drv_reg) & ~$past(wd)))
        else $error("driver disable touched zero bits"); // R5
    a_flt_zero: assert property (@(posedge pclk) disable iff (!presetn)
        s_wr_at(pioc_pkg::PIOC_FLT_EN_OFF)
        |=> (flt_reg & ~$past(wd)) == ($past(flt_reg) & ~$past(wd)))
        else $error("filter enable touched zero bits"); // R7
    a_flt_zclr: assert property (@(posedge pclk) disable iff (!presetn)
        s_wr_at(pioc_pkg::PIOC_FLT_DIS_OFF)
        |=> (flt_reg & ~$past(wd)) == ($past(flt_reg) & ~$past(wd)))
        else $error("filter disable touched zero bits"); // R8
    a_lvl_zero: assert property (@(posedge pclk) disable iff (!presetn)
        s_wr_at(pioc_pkg::PIOC_LVL_SET_OFF)
        |=> (lvl_reg & ~$past(wd)) == ($past(lvl_reg) & ~$past(wd)))
        else $error("level set touched zero bits"); // R10
    a_lvl_zclr: assert property (@(posedge pclk) disable iff (!presetn)
        s_wr_at(pioc_pkg::PIOC_LVL_CLR_OFF)
        |=> (lvl_reg & ~$past(wd)) == ($past(lvl_reg) & ~$past(wd)))
        else $error("level clear touched zero bits"); // R11

    // state moves only through its own write registers
    a_owner_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !(wr && (off == pioc_pkg::PIOC_OWNER_EN_OFF ||
                 off == pioc_pkg::PIOC_OWNER_DIS_OFF))
        |=> $stable(owner_reg)) // R3
        else $error("owner changed without write");
    a_drv_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !(wr && (off == pioc_pkg::PIOC_DRV_EN_OFF ||
                 off == pioc_pkg::PIOC_DRV_DIS_OFF))
        |=> $stable(drv_reg)) // R6
        else $error("driver changed without write");
    a_flt_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !(wr && (off == pioc_pkg::PIOC_FLT_EN_OFF ||
                 off == pioc_pkg::PIOC_FLT_DIS_OFF))
        |=> $stable(flt_reg)) // R9
        else $error("filter changed without write");
    a_lvl_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !(wr && (off == pioc_pkg::PIOC_LVL_SET_OFF ||
                 off == pioc_pkg::PIOC_LVL_CLR_OFF ||
                 off == pioc_pkg::PIOC_LVL_STAT_OFF))
        |=> $stable(lvl_reg)) // R12
        else $error("level changed without write");
    a_dw_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !(wr && (off == pioc_pkg::PIOC_DW_EN_OFF ||
                 off == pioc_pkg::PIOC_DW_DIS_OFF))
        |=> $stable(dwr_reg)) // R14
        else $error("direct-write changed without write");
    a_lvl_direct: assert property (@(posedge pclk) disable iff (!presetn)
        s_wr_at(pioc_pkg::PIOC_LVL_STAT_OFF)
        |=> (lvl_reg & $past(dwr_reg)) == ($past(wd) & $past(dwr_reg)))
        else $error("direct level write lost"); // R14
    a_dw_set: assert property (@(posedge pclk) disable iff (!presetn)
        s_wr_at(pioc_pkg::PIOC_DW_EN_OFF)
        |=> (dwr_reg & $past(wd)) == $past(wd)) // R14
        else $error("direct-write enable did not take");
    a_dw_clr: assert property (@(posedge pclk) disable iff (!presetn)
        s_wr_at(pioc_pkg::PIOC_DW_DIS_OFF)
        |=> (dwr_reg & $past(wd)) == 32'h0000_0000) // R14
        else $error("direct-write disable did not take");
    a_unmap_ign: assert property (@(posedge pclk) disable iff (!presetn)
        wr && !hit
        |=> $stable(owner_reg) && $stable(drv_reg) && $stable(flt_reg)
            && $stable(lvl_reg) && $stable(dwr_reg)) // R15
        else $error("unmapped write changed state");
    a_err_mapped: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && hit |-> !pslverr)
        else $error("error on mapped access");
    a_no_wait: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable |-> pready)
        else $error("access stretched");
    a_periph_excl: assert property (@(posedge pclk) disable iff (!presetn)
        (periph_owned & pin_oe) == 32'h0000_0000) // R17
        else $error("port drives a peripheral line");

    // per-line view of the pad driver, two checkers per line
    for (genvar g = 0; g < 32; g++) begin : g_line
        a_line_drive: assert property (@(posedge pclk)
            disable iff (!presetn)
            owner_reg[g] && drv_reg[g] && LINES_IMPL[g]
            |-> pin_oe[g] && pin_out[g] == lvl_reg[g]) // R17
            else $error("line not driven");
        a_line_float: assert property (@(posedge pclk)
            disable iff (!presetn)
            !(owner_reg[g] && drv_reg[g]) |-> !pin_oe[g] && !pin_out[g])
            else $error("line driven while released"); // R17
    end
endmodule
`default_nettype wire

// ===== sim/pioc_pin_model.sv
// pad model: port drives where enabled, inverted pin_out elsewhere
`timescale 1ns/1ns
`default_nettype none
module pioc_pin_model (
    input  wire logic [31:0] pin_out,
    input  wire logic [31:0] pin_oe,
    output logic      [31:0] pad
);
    // undriven pads show the inverse, so stale levels cannot pass
    assign pad = (pin_out & pin_oe) | (~pin_out & ~pin_oe);
endmodule
`default_nettype wire

// ===== sim/tb_top.sv
// self-checking bench for the line control block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [31:0] paddr, pwdata, prdata, pin_out, pin_oe, periph_owned;
    logic [31:0] filter_on, pad, q;
    int          n_mismatch, cmp_count;
    // line 31 unimplemented, line 0 not shared with a peripheral
    pioc_line_ctrl #(.LINES_IMPL(32'h7fff_ffff), .LINES_MUX(32'hffff_fffe))
    dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pin_out(pin_out),
        .pin_oe(pin_oe), .periph_owned(periph_owned),
        .filter_on(filter_on));
    pioc_pin_model pads (.pin_out(pin_out), .pin_oe(pin_oe), .pad(pad));
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    task complete_run;
        $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] x);
        cmp_count++;
        if (s !== x) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h want %h", $time, s, x);
        end
    endtask
    // setup cycle, then access held until pready is seen high
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {24'h00, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 16);
        q = prdata;
        e = pslverr;
        if (pready !== 1'b1) begin
            n_mismatch++;
            complete_run;
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task rdchk(input logic [7:0] a, input logic [31:0] x);
        xfer(1'b0, a, 32'h0);
        chk(q, x);
    endtask
    task s_reset;
        rdchk(pioc_pkg::PIOC_OWNER_STAT_OFF, 32'h7fff_ffff);
        rdchk(pioc_pkg::PIOC_DRV_STAT_OFF, 32'h0);
        rdchk(pioc_pkg::PIOC_FLT_STAT_OFF, 32'h0);
        rdchk(pioc_pkg::PIOC_LVL_STAT_OFF, 32'h0);
    endtask
    task s_owner;
        xfer(1'b1, pioc_pkg::PIOC_OWNER_DIS_OFF, 32'hffff_0001);
        chk({1'b0, periph_owned[30:0]}, 32'h7fff_0000);
        xfer(1'b1, pioc_pkg::PIOC_OWNER_EN_OFF, 32'h0003_0000);
        xfer(1'b1, pioc_pkg::PIOC_OWNER_STAT_OFF, 32'h0);
        rdchk(pioc_pkg::PIOC_OWNER_STAT_OFF, 32'h0003_ffff);
    endtask
    task s_drv_flt;
        xfer(1'b1, pioc_pkg::PIOC_DRV_EN_OFF, 32'hffff_00ff);
        xfer(1'b1, pioc_pkg::PIOC_DRV_DIS_OFF, 32'h0000_000f);
        rdchk(pioc_pkg::PIOC_DRV_STAT_OFF, 32'h7fff_00f0);
        xfer(1'b1, pioc_pkg::PIOC_FLT_EN_OFF, 32'hffff_ffff);
        xfer(1'b1, pioc_pkg::PIOC_FLT_DIS_OFF, 32'h0000_ff00);
        rdchk(pioc_pkg::PIOC_FLT_STAT_OFF, 32'h7fff_00ff);
        chk({1'b0, filter_on[30:0]}, 32'h7fff_00ff);
    endtask
    task s_level;
        xfer(1'b1, pioc_pkg::PIOC_LVL_SET_OFF, 32'h8000_00ff);
        xfer(1'b1, pioc_pkg::PIOC_LVL_CLR_OFF, 32'h0000_0033);
        rdchk(pioc_pkg::PIOC_LVL_STAT_OFF, 32'h0000_00cc);
        chk(pin_oe, 32'h0003_00f0);
        chk(pin_out, 32'h0000_00c0);
        chk(pad & 32'h0003_00f0, 32'h0000_00c0);
    endtask
    task s_direct;
        xfer(1'b1, pioc_pkg::PIOC_LVL_STAT_OFF, 32'hffff_ffff);
        rdchk(pioc_pkg::PIOC_LVL_STAT_OFF, 32'h0000_00cc);
        xfer(1'b1, pioc_pkg::PIOC_DW_EN_OFF, 32'h0000_000f);
        rdchk(pioc_pkg::PIOC_DW_STAT_OFF, 32'h0000_000f);
        xfer(1'b1, pioc_pkg::PIOC_LVL_STAT_OFF, 32'h0000_0005);
        rdchk(pioc_pkg::PIOC_LVL_STAT_OFF, 32'h0000_00c5);
    endtask
    task s_unmapped;
        xfer(1'b1, 8'hfc, 32'hffff_ffff);
        rdchk(8'h0c, 32'h0);
        chk({31'h0, e}, 32'h1);
        rdchk(pioc_pkg::PIOC_DRV_EN_OFF, 32'h0);
    endtask
    // reset in mid-run must drop the pads and restore ownership
    task s_rereset;
        presetn <= 1'b0;
        @(posedge pclk);
        chk(pin_oe, 32'h0);
        chk(periph_owned, 32'h0);
        presetn <= 1'b1;
        @(posedge pclk);
        rdchk(pioc_pkg::PIOC_OWNER_STAT_OFF, 32'h7fff_ffff);
        rdchk(pioc_pkg::PIOC_DW_STAT_OFF, 32'h0);
        rdchk(pioc_pkg::PIOC_LVL_STAT_OFF, 32'h0);
    endtask
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        n_mismatch = 0;
        cmp_count = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        s_reset;
        s_owner;
        s_drv_flt;
        s_level;
        s_direct;
        s_unmapped;
        s_rereset;
        complete_run;
    end
endmodule
`default_nettype wire
